/* File: core/rxfwp_top.v */
// Receive-side write port of the MAC toward an external receive FIFO.
`timescale 1ns/1ps
`include "rxfwp_consts.vh"
module rxfwp_top (
    input wire CLK_SYS,
    input wire RST_N,
    input wire RX_ENABLE,
    input wire [2:0] BUS_WIDTH,
    input wire IN_VALID,
    output reg IN_READY,
    input wire [`RXFWP_DATA_W-1:0] IN_DATA,
    input wire IN_LAST,
    input wire [3:0] IN_MOD,
    input wire IN_ERR,
    input wire IN_CODE_ERR,
    input wire IN_TOO_LONG,
    input wire IN_TOO_SHORT,
    input wire IN_FCS_ERR,
    input wire IN_LEN_ERR,
    input wire IN_SNAP,
    input wire IN_VLAN_TAGGED,
    input wire IN_VLAN_CFI,
    input wire IN_PRIO_TAGGED,
    input wire [3:0] IN_VLAN_PRIO,
    input wire [2:0] IN_CSUM_OK,
    input wire [3:0] IN_TYPE_MATCH,
    input wire [`RXFWP_NADDR-1:0] IN_ADDR_MATCH,
    input wire [3:0] EXTERNAL_MATCH_INPUT,
    input wire IN_UNI_HASH,
    input wire IN_MULTI_HASH,
    input wire IN_BROADCAST,
    input wire FIFO_OVERFLOW,
    output reg FIFO_WRITE,
    output reg [`RXFWP_DATA_W-1:0] FIFO_DATA,
    output reg FIFO_SOP,
    output reg FIFO_EOP,
    output reg [`RXFWP_STAT_W-1:0] FIFO_STATUS,
    output reg [`RXFWP_NADDR:5] ADDR_MATCH_VEC,
    output reg [3:0] FIFO_MOD,
    output reg FIFO_ERR,
    output reg FIFO_FLUSH
);
    localparam S_IDLE = 2'b00;
    localparam S_FRAME = 2'b01;
    localparam S_DROP = 2'b10;

    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [`RXFWP_LEN_W-1:0] len_reg;
    reg [`RXFWP_LEN_W-1:0] len_next;
    reg ovf_reg;
    reg err_reg;
    reg [4:0] word_bytes;
    reg [4:0] last_bytes;
    reg [`RXFWP_DATA_W-1:0] data_masked;
    reg snap_ok;
    reg [`RXFWP_STAT_W-1:0] stat_word;
    reg bad_frame;
    reg take;
    reg first;

    wire f_in_ready;
    wire f_out_valid;
    wire [`RXFWP_WORD_W-1:0] f_out_data;
    wire [`RXFWP_WORD_W-1:0] f_in_data;
    wire f_pop;

    // Widths of the word in bytes per datapath setting.
    always @* begin
        case (BUS_WIDTH)
            `RXFWP_BUS32: word_bytes = 5'd4;
            `RXFWP_BUS64: word_bytes = 5'd8;
            default: word_bytes = 5'd16;
        endcase
    end

    always @* begin
        data_masked = IN_DATA;
        case (BUS_WIDTH)
            `RXFWP_BUS32: data_masked = {96'h0, IN_DATA[31:0]};
            `RXFWP_BUS64: data_masked = {64'h0, IN_DATA[63:0]};
            default: data_masked = IN_DATA;
        endcase
    end

    always @* begin
        last_bytes = (IN_MOD == 4'h0) ? word_bytes : {1'b0, IN_MOD};
        take = IN_VALID && f_in_ready && RX_ENABLE;
        first = (state_reg == S_IDLE);
    end

    // Status vector assembly.
    always @* begin
        snap_ok = IN_SNAP && (!IN_VLAN_TAGGED || !IN_VLAN_CFI);
        bad_frame = IN_CODE_ERR || IN_TOO_LONG || IN_TOO_SHORT || IN_FCS_ERR
            || IN_LEN_ERR || ovf_reg || FIFO_OVERFLOW || err_reg || IN_ERR;
        len_next = len_reg + {9'h0, last_bytes};
        if (!IN_LAST) begin
            len_next = len_reg + {9'h0, word_bytes};
        end
        stat_word = {`RXFWP_STAT_W{1'b0}};
        stat_word[`RXFWP_ST_CODE_ERR] = IN_CODE_ERR;
        stat_word[`RXFWP_ST_TOO_LONG] = IN_TOO_LONG;
        stat_word[`RXFWP_ST_TOO_SHORT] = IN_TOO_SHORT;
        stat_word[`RXFWP_ST_FCS_ERR] = IN_FCS_ERR;
        stat_word[`RXFWP_ST_LEN_ERR] = IN_LEN_ERR;
        stat_word[`RXFWP_ST_SNAP] = snap_ok;
        stat_word[`RXFWP_ST_CSUM_HI:`RXFWP_ST_CSUM_LO] = IN_CSUM_OK;
        stat_word[`RXFWP_ST_TYPE_HI:`RXFWP_ST_TYPE_LO] = IN_TYPE_MATCH;
        stat_word[`RXFWP_ST_ADDR_HI:`RXFWP_ST_ADDR_LO] = IN_ADDR_MATCH[3:0];
        stat_word[`RXFWP_ST_EXT_HI:`RXFWP_ST_EXT_LO] = EXTERNAL_MATCH_INPUT;
        stat_word[`RXFWP_ST_UNI_HASH] = IN_UNI_HASH;
        stat_word[`RXFWP_ST_MULTI_HASH] = IN_MULTI_HASH;
        stat_word[`RXFWP_ST_BCAST] = IN_BROADCAST;
        stat_word[`RXFWP_ST_PRIO_TAG] = IN_PRIO_TAGGED;
        stat_word[`RXFWP_ST_PRIO_HI:`RXFWP_ST_PRIO_LO] = IN_VLAN_PRIO;
        stat_word[`RXFWP_ST_VLAN_TAG] = IN_VLAN_TAGGED;
        stat_word[`RXFWP_ST_BAD] = bad_frame;
        stat_word[`RXFWP_ST_LEN_HI:0] = len_next;
        if (!IN_LAST) begin
            stat_word[`RXFWP_ST_BAD] = 1'b0;
            stat_word[`RXFWP_ST_LEN_HI:0] = {`RXFWP_LEN_W{1'b0}};
        end
    end

    // Frame tracking state machine.
    always @* begin
        state_next = state_reg;
        case (state_reg)
            S_IDLE: begin
                if (take && !IN_LAST) begin
                    state_next = S_FRAME;
                end
            end
            S_FRAME: begin
                if (!RX_ENABLE) begin
                    state_next = S_DROP;
                end else if (take && IN_LAST) begin
                    state_next = S_IDLE;
                end
            end
            S_DROP: begin
                if (RX_ENABLE && !IN_VALID) begin
                    state_next = S_IDLE;
                end
            end
            default: state_next = S_IDLE;
        endcase
    end

    // Word layout, top down: status, extra matches, then data, sop, eop, mod, err.
    wire [`RXFWP_STAT_W-1:0] st_fifo;
    wire [`RXFWP_NADDR-5:0] am_fifo;
    wire [`RXFWP_DATA_W-1:0] d_fifo;
    wire sop_fifo;
    wire eop_fifo;
    wire [3:0] mod_fifo;
    wire err_fifo;
    wire [`RXFWP_STAT_W+`RXFWP_NADDR-4+`RXFWP_WORD_W-1:0] f_word_in;
    wire [`RXFWP_STAT_W+`RXFWP_NADDR-4+`RXFWP_WORD_W-1:0] f_word_out;

    assign f_in_data = {data_masked, first, IN_LAST, IN_MOD, IN_ERR || FIFO_OVERFLOW,
        1'b0};
    assign f_word_in = {stat_word, IN_ADDR_MATCH[`RXFWP_NADDR-1:4], f_in_data};
    assign st_fifo = f_word_out[208:164];
    assign am_fifo = f_word_out[163:136];
    assign d_fifo = f_word_out[135:8];
    assign sop_fifo = f_word_out[7];
    assign eop_fifo = f_word_out[6];
    assign mod_fifo = f_word_out[5:2];
    assign err_fifo = f_word_out[1];
    assign f_pop = f_out_valid;

    rxfwp_fifo #(
        .WIDTH(`RXFWP_STAT_W+`RXFWP_NADDR-4+`RXFWP_WORD_W),
        .DEPTH(`RXFWP_FIFO_DEPTH),
        .AW(`RXFWP_FIFO_AW)
    ) u_fifo (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .clear(!RX_ENABLE),
        .in_valid(take),
        .in_ready(f_in_ready),
        .in_data(f_word_in),
        .out_valid(f_out_valid),
        .out_ready(f_pop),
        .out_data(f_word_out)
    );

    // Bookkeeping registers; the system resets this domain synchronously here.
    always @(posedge CLK_SYS) begin
        if (!RST_N) begin
            state_reg <= S_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always @(posedge CLK_SYS) begin
        if (!RST_N) begin
            IN_READY <= 1'b0;
        end else begin
            IN_READY <= f_in_ready && RX_ENABLE;
        end
    end

    always @(posedge CLK_SYS) begin
        if (!RST_N) begin
            len_reg <= {`RXFWP_LEN_W{1'b0}};
        end else if ((take && IN_LAST) || state_reg == S_DROP) begin
            len_reg <= {`RXFWP_LEN_W{1'b0}};
        end else if (take) begin
            len_reg <= len_next;
        end
    end

    always @(posedge CLK_SYS) begin
        if (!RST_N) begin
            ovf_reg <= 1'b0;
        end else if ((take && IN_LAST) || state_reg == S_DROP) begin
            ovf_reg <= 1'b0;
        end else if (FIFO_OVERFLOW && state_reg == S_FRAME) begin
            ovf_reg <= 1'b1;
        end
    end

    always @(posedge CLK_SYS) begin
        if (!RST_N) begin
            err_reg <= 1'b0;
        end else if ((take && IN_LAST) || state_reg == S_DROP) begin
            err_reg <= 1'b0;
        end else if (take) begin
            err_reg <= err_reg || IN_ERR;
        end
    end

    // Output stage toward the external FIFO.
    always @(posedge CLK_SYS) begin
        if (!RST_N) begin
            FIFO_FLUSH <= 1'b0;
        end else begin
            FIFO_FLUSH <= !RX_ENABLE;
        end
    end

    always @(posedge CLK_SYS) begin
        if (!RST_N) begin
            FIFO_WRITE <= 1'b0;
        end else begin
            FIFO_WRITE <= f_pop && RX_ENABLE;
        end
    end

    always @(posedge CLK_SYS) begin
        if (!RST_N) begin
            FIFO_DATA <= {`RXFWP_DATA_W{1'b0}};
        end else begin
            FIFO_DATA <= d_fifo;
        end
    end

    always @(posedge CLK_SYS) begin
        if (!RST_N) begin
            FIFO_SOP <= 1'b0;
        end else begin
            FIFO_SOP <= sop_fifo && f_pop && RX_ENABLE;
        end
    end

    always @(posedge CLK_SYS) begin
        if (!RST_N) begin
            FIFO_EOP <= 1'b0;
        end else begin
            FIFO_EOP <= eop_fifo && f_pop && RX_ENABLE;
        end
    end

    always @(posedge CLK_SYS) begin
        if (!RST_N) begin
            FIFO_STATUS <= {`RXFWP_STAT_W{1'b0}};
        end else begin
            FIFO_STATUS <= st_fifo;
        end
    end

    always @(posedge CLK_SYS) begin
        if (!RST_N) begin
            ADDR_MATCH_VEC <= {(`RXFWP_NADDR-4){1'b0}};
        end else begin
            ADDR_MATCH_VEC <= eop_fifo ? am_fifo : {(`RXFWP_NADDR-4){1'b0}};
        end
    end

    always @(posedge CLK_SYS) begin
        if (!RST_N) begin
            FIFO_MOD <= 4'h0;
        end else begin
            FIFO_MOD <= eop_fifo ? mod_fifo : 4'h0;
        end
    end

    always @(posedge CLK_SYS) begin
        if (!RST_N) begin
            FIFO_ERR <= 1'b0;
        end else begin
            FIFO_ERR <= err_fifo && f_pop;
        end
    end
endmodule

/* File: core/rxfwp_consts.vh */
// Constants for the receive FIFO write port.
`ifndef RXFWP_CONSTS_VH
`define RXFWP_CONSTS_VH
`define RXFWP_DATA_W 128
`define RXFWP_STAT_W 45
`define RXFWP_FIFO_DEPTH 4
`define RXFWP_FIFO_AW 2
`define RXFWP_WORD_W 136
`define RXFWP_BUS32 3'b000
`define RXFWP_BUS64 3'b001
`define RXFWP_BUS128 3'b010
`define RXFWP_ST_CODE_ERR 44
`define RXFWP_ST_TOO_LONG 43
`define RXFWP_ST_TOO_SHORT 42
`define RXFWP_ST_FCS_ERR 41
`define RXFWP_ST_LEN_ERR 40
`define RXFWP_ST_SNAP 39
`define RXFWP_ST_CSUM_HI 38
`define RXFWP_ST_CSUM_LO 36
`define RXFWP_ST_TYPE_HI 35
`define RXFWP_ST_TYPE_LO 32
`define RXFWP_ST_ADDR_HI 31
`define RXFWP_ST_ADDR_LO 28
`define RXFWP_ST_EXT_HI 27
`define RXFWP_ST_EXT_LO 24
`define RXFWP_ST_UNI_HASH 23
`define RXFWP_ST_MULTI_HASH 22
`define RXFWP_ST_BCAST 21
`define RXFWP_ST_PRIO_TAG 20
`define RXFWP_ST_PRIO_HI 19
`define RXFWP_ST_PRIO_LO 16
`define RXFWP_ST_VLAN_TAG 15
`define RXFWP_ST_BAD 14
`define RXFWP_ST_LEN_HI 13
`define RXFWP_LEN_W 14
`define RXFWP_NADDR 32
`endif

/* File: core/rxfwp_fifo.v */
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module rxfwp_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    input wire clk,
    input wire rst_n,
    input wire clear,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_reg;
    reg [AW-1:0] rd_ptr_reg;
    reg [AW:0] count_reg;
    wire push;
    wire pop;

    assign in_ready = (count_reg != DEPTH[AW:0]);
    assign out_valid = (count_reg != {(AW+1){1'b0}});
    assign out_data = mem[rd_ptr_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    always @(posedge clk) begin
        if (!rst_n || clear) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule

/* File: tb/rxfwp_far_fifo.sv */
// Model of the external receive FIFO fed by the write port.
`timescale 1ns/1ps
module rxfwp_far_fifo #(
    parameter int CAP = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr,
    input wire logic flush,
    input wire logic stall,
    output logic overflow = 1'b0
);
    int fill = 0;
    // A strobed word is taken only while there is room; a strobe into a full store raises a sticky overflow.
    always @(posedge clk) begin
        if (!rst_n || flush) begin
            fill <= 0;
            overflow <= 1'b0;
        end else begin
            if (wr && fill == CAP)
                overflow <= 1'b1;
            fill <= fill + int'(wr && fill < CAP) - int'(!stall && fill > 0);
        end
    end
endmodule

/* File: tb/rxfwp_checker.sv */
// Assertions on the ports of the receive FIFO write port.
`timescale 1ns/1ps
`include "rxfwp_consts.vh"
module rxfwp_checker (
    input wire CLK_SYS,
    input wire RST_N,
    input wire RX_ENABLE,
    input wire IN_VALID,
    input wire IN_READY,
    input wire IN_LAST,
    input wire FIFO_WRITE,
    input wire FIFO_SOP,
    input wire FIFO_EOP,
    input wire [`RXFWP_STAT_W-1:0] FIFO_STATUS,
    input wire FIFO_FLUSH
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    reg in_frame_reg;
    always @(posedge CLK_SYS) begin
        if (!RST_N || FIFO_FLUSH)
            in_frame_reg <= 1'b0;
        else if (FIFO_WRITE)
            in_frame_reg <= !FIFO_EOP;
    end
    sequence s_take;
        IN_VALID && IN_READY && RX_ENABLE;
    endsequence
    sequence s_off3;
        !RX_ENABLE [*3];
    endsequence
    a_take_to_write: assert property (s_take |-> ##[2:6] (FIFO_WRITE || !RX_ENABLE))
        else $error("taken word not written");
    a_last_to_eop: assert property (s_take ##0 IN_LAST |-> ##[2:6] (FIFO_WRITE && FIFO_EOP || FIFO_FLUSH))
        else $error("last word without end marker");
    a_flush_when_off: assert property (!RX_ENABLE |=> FIFO_FLUSH)
        else $error("flush missing while disabled");
    a_flush_when_on: assert property (RX_ENABLE |=> !FIFO_FLUSH)
        else $error("flush while enabled");
    a_off_no_write: assert property (s_off3 |=> !FIFO_WRITE)
        else $error("write while disabled");
    a_sop_on_first: assert property (FIFO_WRITE && !in_frame_reg |-> FIFO_SOP)
        else $error("first word lacks start marker");
    a_sop_not_mid: assert property (FIFO_WRITE && in_frame_reg |-> !FIFO_SOP)
        else $error("start marker inside frame");
    a_status_mid_zero: assert property (FIFO_WRITE && !FIFO_EOP |-> FIFO_STATUS[14:0] == 15'h0)
        else $error("length field set before end");
endmodule
bind rxfwp_top rxfwp_checker u_chk (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .RX_ENABLE(RX_ENABLE),
    .IN_VALID(IN_VALID), .IN_READY(IN_READY), .IN_LAST(IN_LAST), .FIFO_WRITE(FIFO_WRITE),
    .FIFO_SOP(FIFO_SOP), .FIFO_EOP(FIFO_EOP), .FIFO_STATUS(FIFO_STATUS), .FIFO_FLUSH(FIFO_FLUSH));

/* File: tb/rx_fifo_write_port_test.sv */
// Self-checking bench for the receive FIFO write port.
`timescale 1ns/1ps
`include "rxfwp_consts.vh"
module rx_fifo_write_port_test;
    logic CLK_SYS = 0, RST_N = 0, RX_ENABLE = 1, IN_VALID = 0, IN_LAST = 0, IN_ERR = 0, stall = 0;
    logic [2:0] BUS_WIDTH = 0, bw = 0;
    logic [127:0] IN_DATA = 0;
    logic [3:0] IN_MOD = 0;
    logic [4:0] errs = 0;
    logic [53:0] attr = 0;
    logic ovf_d1 = 0, ovf_d2 = 0;
    wire IN_READY, FIFO_OVERFLOW, FIFO_WRITE, FIFO_SOP, FIFO_EOP, FIFO_ERR, FIFO_FLUSH;
    wire [127:0] FIFO_DATA;
    wire [44:0] FIFO_STATUS;
    wire [32:5] ADDR_MATCH_VEC;
    wire [3:0] FIFO_MOD;
    logic [207:0] exp_q[$], msk_q[$], e, m;
    int fail_count = 0, tests_run = 0, cycles = 0, seed;
    rxfwp_top dut (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .RX_ENABLE(RX_ENABLE), .BUS_WIDTH(BUS_WIDTH),
        .IN_VALID(IN_VALID), .IN_READY(IN_READY), .IN_DATA(IN_DATA), .IN_LAST(IN_LAST),
        .IN_MOD(IN_MOD), .IN_ERR(IN_ERR), .IN_CODE_ERR(errs[4]), .IN_TOO_LONG(errs[3]),
        .IN_TOO_SHORT(errs[2]), .IN_FCS_ERR(errs[1]), .IN_LEN_ERR(errs[0]), .IN_SNAP(attr[53]),
        .IN_VLAN_TAGGED(attr[52]), .IN_VLAN_CFI(attr[51]), .IN_PRIO_TAGGED(attr[50]),
        .IN_VLAN_PRIO(attr[49:46]), .IN_CSUM_OK(attr[45:43]), .IN_TYPE_MATCH(attr[42:39]),
        .IN_ADDR_MATCH(attr[38:7]), .EXTERNAL_MATCH_INPUT(attr[6:3]), .IN_UNI_HASH(attr[2]),
        .IN_MULTI_HASH(attr[1]), .IN_BROADCAST(attr[0]), .FIFO_OVERFLOW(FIFO_OVERFLOW),
        .FIFO_WRITE(FIFO_WRITE), .FIFO_DATA(FIFO_DATA), .FIFO_SOP(FIFO_SOP), .FIFO_EOP(FIFO_EOP),
        .FIFO_STATUS(FIFO_STATUS), .ADDR_MATCH_VEC(ADDR_MATCH_VEC), .FIFO_MOD(FIFO_MOD),
        .FIFO_ERR(FIFO_ERR), .FIFO_FLUSH(FIFO_FLUSH));
    rxfwp_far_fifo #(.CAP(2)) far (.clk(CLK_SYS), .rst_n(RST_N), .wr(FIFO_WRITE),
        .flush(FIFO_FLUSH), .stall(stall), .overflow(FIFO_OVERFLOW));
    always #20 CLK_SYS = ~CLK_SYS;
    task automatic test_done;
        if (exp_q.size() != 0) fail_count++;
        if (fail_count == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input logic [207:0] g, input logic [207:0] x);
        tests_run++;
        if (g !== x) begin
            fail_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, g, x);
        end
    endtask
    // Sends one frame and notes the expected words; a cut frame never ends.
    task automatic frame(input int n, input bit ovf, input bit cut);
        int bpw;
        logic [13:0] len;
        logic bad, last, err;
        logic [3:0] mod;
        logic [127:0] d, mk;
        logic [53:0] a;
        logic [4:0] er;
        bpw = bw == 3'h0 ? 4 : bw == 3'h1 ? 8 : 16;
        mk = {128{1'b1}} >> (128 - 8 * bpw);
        a = 54'({$urandom, $urandom});
        er = 5'($urandom);
        bad = ovf | (|er);
        len = 14'h0;
        for (int i = 0; i < n; i++) begin
            d = {$urandom, $urandom, $urandom, $urandom};
            last = (i == n - 1) && !cut;
            err = ($urandom % 5) == 0;
            mod = last ? 4'($urandom % bpw) : 4'h0;
            bad = bad | err;
            len = len + 14'((last && mod != 4'h0) ? mod : bpw);
            exp_q.push_back({last, i == 0, mod, err, a[38:11], er, a[53] & (!a[52] | !a[51]),
                a[45:39], a[10:0], a[50:46], a[52], bad & last, last ? len : 14'h0, d & mk});
            msk_q.push_back(last ? '1 : {7'h61, 52'h0, 21'h1fffff, {128{1'b1}}});
            @(posedge CLK_SYS);
            attr <= a;
            errs <= er;
            IN_VALID <= 1'b1;
            IN_DATA <= d;
            IN_LAST <= last;
            IN_MOD <= mod;
            IN_ERR <= err;
        end
        @(posedge CLK_SYS);
        IN_VALID <= 1'b0;
        IN_LAST <= 1'b0;
    endtask
    always @(posedge CLK_SYS) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            test_done();
        end
    end
    // Overflow as the port saw it at the edge that took the word now written.
    always @(posedge CLK_SYS) begin
        ovf_d1 <= FIFO_OVERFLOW;
        ovf_d2 <= ovf_d1;
    end
    always @(negedge CLK_SYS) begin
        if (RST_N && FIFO_WRITE === 1'b1) begin
            e = 'x;
            m = '1;
            if (exp_q.size() > 0) begin
                e = exp_q.pop_front();
                m = msk_q.pop_front();
                if (ovf_d2 === 1'b1) e[201] = 1'b1;
            end
            check({FIFO_EOP, FIFO_SOP, FIFO_MOD, FIFO_ERR, ADDR_MATCH_VEC, FIFO_STATUS, FIFO_DATA} & m, e & m);
        end
    end
    initial begin
        seed = $urandom(35);
        repeat (3) @(posedge CLK_SYS);
        RST_N <= 1'b1;
        for (int w = 0; w < 4; w++) begin
            repeat (4) @(posedge CLK_SYS);
            bw = 3'(w);
            BUS_WIDTH <= bw;
            for (int k = 1; k <= 6; k++) frame(k, 1'b0, 1'b0);
        end
        stall <= 1'b1;
        frame(8, 1'b1, 1'b0);
        stall <= 1'b0;
        frame(3, 1'b0, 1'b1);
        repeat (4) @(posedge CLK_SYS);
        RX_ENABLE <= 1'b0;
        @(posedge CLK_SYS);
        IN_VALID <= 1'b1;
        @(negedge CLK_SYS);
        check(208'(FIFO_FLUSH), 208'h1);
        repeat (3) @(posedge CLK_SYS);
        RX_ENABLE <= 1'b1;
        IN_VALID <= 1'b0;
        frame(2, 1'b0, 1'b0);
        repeat (8) @(posedge CLK_SYS);
        test_done();
    end
endmodule
